// ==== design/fkas_mode_strap.sv ====
// Start-up mode capture after reset release
`timescale 1ns/10ps
`default_nettype none
module fkas_mode_strap
  import fkas_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] mode_strap,
  output var  fkas_mode_t mode,
  output var  logic       mode_valid
);

  typedef struct packed {
    logic       valid;
    fkas_mode_t mode;
  } fkas_strap_st_t;

  fkas_strap_st_t s_q;
  fkas_strap_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.valid) begin
      s_d.valid = 1'b1;
      s_d.mode  = fkas_mode_t'(mode_strap);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{valid: 1'b0, mode: FKAS_MODE_USER_PROG};
    end else begin
      s_q <= s_d;
    end
  end

  assign mode       = s_q.mode;
  assign mode_valid = s_q.valid;

endmodule : fkas_mode_strap
`default_nettype wire

// ==== design/fkas_pe_gate.sv ====
// Gate between the programming routine and the flash write strobe
`timescale 1ns/10ps
`default_nettype none
module fkas_pe_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pe_enable,
  input  wire logic pe_request,
  output var  logic pe_strobe
);

  typedef struct packed {
    logic strobe;
  } fkas_gate_st_t;

  fkas_gate_st_t s_q;
  fkas_gate_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.strobe = pe_request & pe_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{strobe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pe_strobe = s_q.strobe;

endmodule : fkas_pe_gate
`default_nettype wire

// ==== design/fkas_pkg.sv ====
// Constants, types and helpers for the flash key and array select block
//
// Overview of operation
// - The copy request bit can only be set while the key register holds A5.
// - With any other key, a write of one to the copy request bit is ignored and nothing starts.
// - Programming or erasure is passed to the flash only while the key register holds 5A.
// - With any other key no programming or erasure passes and the block stays protected.
// - The key register is eight read/write bits that reset to 00.
// - The array select register holding AA maps the user boot array into flash space.
// - Any other array select value presents the user array.
// - After reset the array select register holds AA in user boot mode and 00 otherwise.
// - In user programming mode no write can make the array select register select boot.
// - In boot mode and programmer mode a write of AA selects the user boot array.
// - The copy request bit clears itself when the download finishes and always reads 0.
// - Setting the copy request bit also needs the RAM emulation select bit to be clear.
package fkas_pkg;

  localparam int          FKAS_ADDR_W   = 8;
  localparam logic [7:0]  FKAS_KEY_COPY = 8'hA5;
  localparam logic [7:0]  FKAS_KEY_PE   = 8'h5A;
  localparam logic [7:0]  FKAS_KEY_RST  = 8'h00;
  localparam logic [7:0]  FKAS_ARR_BOOT = 8'hAA;
  localparam logic [7:0]  FKAS_ARR_USER = 8'h00;

  localparam logic [7:0]  FKAS_OFS_KEY  = 8'h00;
  localparam logic [7:0]  FKAS_OFS_ARR  = 8'h04;
  localparam logic [7:0]  FKAS_OFS_COPY = 8'h08;
  localparam logic [7:0]  FKAS_OFS_EMUL = 8'h0C;
  localparam logic [7:0]  FKAS_OFS_STAT = 8'h10;

  localparam int          FKAS_COPY_REQ_BIT  = 0;
  localparam int          FKAS_COPY_BUSY_BIT = 1;
  localparam int          FKAS_EMUL_SEL_BIT  = 0;
  localparam int          FKAS_STAT_PE_BIT   = 0;
  localparam int          FKAS_STAT_BOOT_BIT = 1;
  localparam int          FKAS_STAT_MODE_LSB = 2;
  localparam int          FKAS_STAT_BUSY_BIT = 4;

  typedef enum logic [1:0] {
    FKAS_MODE_USER_PROG  = 2'h0,
    FKAS_MODE_USER_BOOT  = 2'h1,
    FKAS_MODE_BOOT       = 2'h2,
    FKAS_MODE_PROGRAMMER = 2'h3
  } fkas_mode_t;

  typedef enum logic [2:0] {
    FKAS_DL_IDLE  = 3'h1,
    FKAS_DL_START = 3'h2,
    FKAS_DL_WAIT  = 3'h4
  } fkas_dl_t;

  function automatic logic fkas_is_copy_key(input logic [7:0] key);
    return key == FKAS_KEY_COPY;
  endfunction : fkas_is_copy_key

  function automatic logic fkas_is_pe_key(input logic [7:0] key);
    return key == FKAS_KEY_PE;
  endfunction : fkas_is_pe_key

endpackage : fkas_pkg

// ==== design/fkas_top.sv ====
// Key code and array select registers with APB access
`timescale 1ns/10ps
`default_nettype none
module fkas_top
  import fkas_pkg::*;
#(
  parameter int ADDR_W = FKAS_ADDR_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [1:0]        mode_strap,
  input  wire logic              download_done,
  input  wire logic              pe_request,
  output var  logic              copy_start,
  output var  logic              copy_busy,
  output var  logic              boot_array_sel,
  output var  logic              pe_enable,
  output var  logic              sw_protect,
  output var  logic              pe_strobe
);

  typedef struct packed {
    logic [7:0]  key;
    logic [7:0]  arr;
    logic        emul;
    fkas_dl_t    dl;
    logic        init;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
    logic        start;
    logic        busy;
    logic        bsel;
    logic        pe_en;
    logic        prot;
  } fkas_st_t;

  localparam fkas_st_t FKAS_ST_RST = '{
    key:   FKAS_KEY_RST,
    arr:   FKAS_ARR_USER,
    emul:  1'b0,
    dl:    FKAS_DL_IDLE,
    init:  1'b0,
    rdy:   1'b0,
    err:   1'b0,
    rdata: 32'h0000_0000,
    start: 1'b0,
    busy:  1'b0,
    bsel:  1'b0,
    pe_en: 1'b0,
    prot:  1'b1
  };

  fkas_st_t   s_q;
  fkas_st_t   s_d;
  fkas_mode_t mode;
  logic       mode_valid;
  logic [7:0] addr8;
  logic       access;
  logic       wr_lo;
  logic       copy_set;
  logic       boot_ok;

  fkas_mode_strap u_strap (
    .pclk       (pclk),
    .presetn    (presetn),
    .mode_strap (mode_strap),
    .mode       (mode),
    .mode_valid (mode_valid)
  );

  fkas_pe_gate u_gate (
    .pclk       (pclk),
    .presetn    (presetn),
    .pe_enable  (s_q.pe_en),
    .pe_request (pe_request),
    .pe_strobe  (pe_strobe)
  );

  function automatic logic fkas_hit(input logic [7:0] a);
    return (a == FKAS_OFS_KEY) || (a == FKAS_OFS_ARR) || (a == FKAS_OFS_COPY)
        || (a == FKAS_OFS_EMUL) || (a == FKAS_OFS_STAT);
  endfunction : fkas_hit

  function automatic logic [31:0] fkas_read(input logic [7:0] a, input fkas_st_t s,
                                            input fkas_mode_t m);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      FKAS_OFS_KEY:  v[7:0] = s.key;
      FKAS_OFS_ARR:  v[7:0] = s.arr;
      FKAS_OFS_COPY: v[FKAS_COPY_BUSY_BIT] = s.busy; // Request bit reads 0
      FKAS_OFS_EMUL: v[FKAS_EMUL_SEL_BIT] = s.emul;
      FKAS_OFS_STAT: begin
        v[FKAS_STAT_PE_BIT]                     = s.pe_en;
        v[FKAS_STAT_BOOT_BIT]                   = s.bsel;
        v[FKAS_STAT_MODE_LSB+1:FKAS_STAT_MODE_LSB] = m;
        v[FKAS_STAT_BUSY_BIT]                   = s.busy;
      end
      default:       v = 32'h0000_0000;
    endcase
    return v;
  endfunction : fkas_read

  // Decode of the access phase
  always_comb begin
    addr8    = 8'(paddr);
    access   = psel & penable & s_q.rdy;
    wr_lo    = access & pwrite & pstrb[0] & s_q.init;
    boot_ok  = (mode != FKAS_MODE_USER_PROG);
    copy_set = wr_lo && (addr8 == FKAS_OFS_COPY) && pwdata[FKAS_COPY_REQ_BIT]
            && fkas_is_copy_key(s_q.key) && !s_q.emul
            && (s_q.dl == FKAS_DL_IDLE);
  end

  always_comb begin
    s_d = s_q;
    // Bus answer prepared in the setup cycle
    s_d.rdy   = psel & ~penable;
    s_d.err   = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (psel && !penable) begin
      s_d.err = !fkas_hit(addr8);
      if (!pwrite) begin
        s_d.rdata = fkas_read(addr8, s_q, mode);
      end
    end
    // Array select loaded from the start-up mode
    if (!s_q.init && mode_valid) begin
      s_d.init = 1'b1;
      s_d.arr  = (mode == FKAS_MODE_USER_BOOT) ? FKAS_ARR_BOOT : FKAS_ARR_USER;
    end
    // Register writes
    if (wr_lo) begin
      case (addr8)
        FKAS_OFS_KEY:  s_d.key = pwdata[7:0];
        FKAS_OFS_ARR: begin
          if (pwdata[7:0] == FKAS_ARR_BOOT && !boot_ok) begin
            s_d.arr = FKAS_ARR_USER;
          end else begin
            s_d.arr = pwdata[7:0];
          end
        end
        FKAS_OFS_EMUL: s_d.emul = pwdata[FKAS_EMUL_SEL_BIT];
        default:       s_d.emul = s_q.emul;
      endcase
    end
    // Download request sequencing
    s_d.start = 1'b0;
    case (s_q.dl)
      FKAS_DL_IDLE: begin
        if (copy_set) begin
          s_d.dl    = FKAS_DL_START;
          s_d.start = 1'b1;
        end
      end
      FKAS_DL_START: s_d.dl = FKAS_DL_WAIT;
      FKAS_DL_WAIT: begin
        if (download_done) begin
          s_d.dl = FKAS_DL_IDLE;
        end
      end
      default:       s_d.dl = FKAS_DL_IDLE;
    endcase
    s_d.busy  = (s_d.dl != FKAS_DL_IDLE);
    // Derived flags follow the stored values
    s_d.bsel  = (s_q.arr == FKAS_ARR_BOOT);
    s_d.pe_en = fkas_is_pe_key(s_q.key);
    s_d.prot  = !fkas_is_pe_key(s_q.key);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= FKAS_ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata         = s_q.rdata;
  assign pready         = s_q.rdy;
  assign pslverr        = s_q.err;
  assign copy_start     = s_q.start;
  assign copy_busy      = s_q.busy;
  assign boot_array_sel = s_q.bsel;
  assign pe_enable      = s_q.pe_en;
  assign sw_protect     = s_q.prot;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence copy_req_s;
    wr_lo && (addr8 == FKAS_OFS_COPY) && pwdata[FKAS_COPY_REQ_BIT] && s_q.dl == FKAS_DL_IDLE;
  endsequence

  sequence copy_run_s;
    copy_start && copy_busy ##1 !copy_start && copy_busy;
  endsequence

  property copy_flow_p;
    copy_req_s and (fkas_is_copy_key(s_q.key) && !s_q.emul) |=> copy_run_s;
  endproperty

  copy_key_a: assert property (copy_start |-> $past(s_q.key) == FKAS_KEY_COPY)
    else $error("copy started without the copy key");

  copy_flow_a: assert property (copy_flow_p)
    else $error("accepted copy request did not start");

  copy_block_a: assert property (copy_req_s and !fkas_is_copy_key(s_q.key) |=> !copy_start
                                 ##1 !copy_busy)
    else $error("copy started with a wrong key");

  pe_pass_a: assert property (pe_request && fkas_is_pe_key($past(s_q.key)) |=> pe_strobe)
    else $error("program strobe not passed with the program key");

  pe_block_a: assert property (!fkas_is_pe_key(s_q.key) |=> !pe_enable && sw_protect
                               ##1 !pe_strobe)
    else $error("program strobe passed while protected");

  key_reset_a: assert property (!s_q.init |-> s_q.key == FKAS_KEY_RST && !copy_busy)
    else $error("key not at reset value before start-up");

  boot_sel_a: assert property (boot_array_sel |-> $past(s_q.arr) == FKAS_ARR_BOOT)
    else $error("boot array selected without AA");

  user_sel_a: assert property (s_q.arr != FKAS_ARR_BOOT |=> !boot_array_sel)
    else $error("user array not presented");

  arr_init_a: assert property (!s_q.init && mode_valid |=>
                               s_q.arr == ((mode == FKAS_MODE_USER_BOOT) ?
                                           FKAS_ARR_BOOT : FKAS_ARR_USER))
    else $error("array select start-up value wrong");

  user_prog_a: assert property (s_q.init && mode == FKAS_MODE_USER_PROG && s_q.arr != FKAS_ARR_BOOT
                                |=> s_q.arr != FKAS_ARR_BOOT)
    else $error("boot array selected in user programming mode");

  boot_mode_a: assert property (wr_lo && addr8 == FKAS_OFS_ARR && pwdata[7:0] == FKAS_ARR_BOOT
                                && boot_ok |=> s_q.arr == FKAS_ARR_BOOT ##1 boot_array_sel)
    else $error("boot array write not taken");

  copy_done_a: assert property (s_q.dl == FKAS_DL_WAIT && download_done |=> !copy_busy)
    else $error("request bit not cleared after download");

  copy_read_a: assert property (pready && !pwrite && addr8 == FKAS_OFS_COPY
                                |-> !prdata[FKAS_COPY_REQ_BIT])
    else $error("request bit read back as one");

  emul_block_a: assert property (copy_req_s and s_q.emul |=> !copy_start)
    else $error("copy started in RAM emulation");

  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready || (psel && !penable))
    else $error("APB answer timing wrong");

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_read_s;
    pready && !pwrite;
  endsequence

  apb_err_a: assert property (apb_setup_s and !fkas_hit(addr8)
                              |=> pready && pslverr)
    else $error("unmapped address answered without error");

  apb_ok_a: assert property (apb_setup_s and fkas_hit(addr8)
                             |=> pready && !pslverr)
    else $error("mapped address answered with error");

  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag outside the access phase");

  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside the access phase");

  key_write_a: assert property (wr_lo && addr8 == FKAS_OFS_KEY
                                |=> s_q.key == $past(pwdata[7:0]))
    else $error("key write not stored");

  key_hold_a: assert property (!(wr_lo && addr8 == FKAS_OFS_KEY) |=> $stable(s_q.key))
    else $error("key changed without a write");

  key_read_a: assert property (apb_read_s and addr8 == FKAS_OFS_KEY
                               |-> prdata == {24'h00_0000, $past(s_q.key)})
    else $error("key read back wrong");

  arr_read_a: assert property (apb_read_s and addr8 == FKAS_OFS_ARR
                               |-> prdata == {24'h00_0000, $past(s_q.arr)})
    else $error("array select read back wrong");

  strb_drop_a: assert property (access && pwrite && !pstrb[0] && s_q.init
                                |=> $stable(s_q.key) && $stable(s_q.arr) && $stable(s_q.emul))
    else $error("write without the low byte strobe took effect");

  err_drop_a: assert property (access && pwrite && !fkas_hit(addr8) && s_q.init
                               |=> $stable(s_q.key) && $stable(s_q.arr) && $stable(s_q.emul))
    else $error("write to an unmapped address took effect");

  early_drop_a: assert property (!s_q.init |=> $stable(s_q.key) && $stable(s_q.emul))
    else $error("write taken before start-up finished");

  copy_pulse_a: assert property (copy_start |=> !copy_start)
    else $error("copy start longer than one cycle");

  busy_rise_a: assert property ($rose(copy_busy) |-> copy_start)
    else $error("busy raised without a copy start");

  busy_hold_a: assert property (copy_busy && !(s_q.dl == FKAS_DL_WAIT && download_done)
                                |=> copy_busy)
    else $error("busy dropped before the download finished");

  busy_refuse_a: assert property (copy_busy |=> !copy_start)
    else $error("copy restarted while busy");

  prot_inv_a: assert property (sw_protect != pe_enable)
    else $error("protect flag not the inverse of the program enable");

  strobe_src_a: assert property (pe_strobe |-> $past(pe_enable) && $past(pe_request))
    else $error("program strobe without an enabled request");

  strobe_prot_a: assert property (sw_protect |=> !pe_strobe)
    else $error("program strobe passed while protected");

  stat_read_a: assert property (apb_read_s and addr8 == FKAS_OFS_STAT
                                |-> prdata[FKAS_STAT_PE_BIT] == $past(pe_enable)
                                    && prdata[FKAS_STAT_BOOT_BIT] == $past(boot_array_sel)
                                    && prdata[FKAS_STAT_BUSY_BIT] == $past(copy_busy))
    else $error("status read back wrong");

  copy_busy_rd_a: assert property (apb_read_s and addr8 == FKAS_OFS_COPY
                                   |-> prdata[FKAS_COPY_BUSY_BIT] == $past(copy_busy))
    else $error("copy busy read back wrong");

  mode_hold_a: assert property (mode_valid |=> $stable(mode))
    else $error("start-up mode changed after capture");

endmodule : fkas_top
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the flash key and array select block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fkas_pkg::*;

  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        pe;
  } fkas_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  mode_strap;
  logic        download_done;
  logic        pe_request;
  logic        copy_start;
  logic        copy_busy;
  logic        boot_array_sel;
  logic        pe_enable;
  logic        sw_protect;
  logic        pe_strobe;
  logic [31:0] rdv;
  logic        erv;
  int          n_errors;
  int          check_count;
  int          n_start;
  int          cycles;
  int          base;

  fkas_row_t rows [6] = '{
    '{FKAS_OFS_KEY,  32'h0000005A, 32'h0000005A, 1'b1},
    '{FKAS_OFS_KEY,  32'hFFFFFFA5, 32'h000000A5, 1'b0},
    '{FKAS_OFS_KEY,  32'h0000003C, 32'h0000003C, 1'b0},
    '{FKAS_OFS_ARR,  32'h00000055, 32'h00000055, 1'b0},
    '{FKAS_OFS_EMUL, 32'h00000001, 32'h00000001, 1'b0},
    '{FKAS_OFS_EMUL, 32'h00000000, 32'h00000000, 1'b0}
  };

  fkas_top dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pstrb          (pstrb),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .mode_strap     (mode_strap),
    .download_done  (download_done),
    .pe_request     (pe_request),
    .copy_start     (copy_start),
    .copy_busy      (copy_busy),
    .boot_array_sel (boot_array_sel),
    .pe_enable      (pe_enable),
    .sw_protect     (sw_protect),
    .pe_strobe      (pe_strobe)
  );

  always #12.5 pclk = ~pclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
  endtask : rchk

  task automatic do_reset(input logic [1:0] m);
    presetn    <= 1'b0;
    mode_strap <= m;
    repeat (2) @(posedge pclk);
    chk({31'h0, sw_protect}, 32'h1);
    chk({31'h0, pe_enable}, 32'h0);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  always @(posedge pclk) begin
    if (copy_start === 1'b1) begin
      n_start <= n_start + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      test_done();
    end
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hF; mode_strap = 2'h0;
    download_done = 1'b0; pe_request = 1'b0;
    n_errors = 0; check_count = 0; n_start = 0; cycles = 0;
    // Start-up value and boot selection per mode
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      rchk(FKAS_OFS_KEY, 32'h0);
      rchk(FKAS_OFS_ARR, (m == 1) ? 32'hAA : 32'h0);
      chk({31'h0, boot_array_sel}, (m == 1) ? 32'h1 : 32'h0);
      wr(FKAS_OFS_ARR, 32'hAA);
      rchk(FKAS_OFS_ARR, (m == 0) ? 32'h0 : 32'hAA);
      chk({31'h0, boot_array_sel}, (m == 0) ? 32'h0 : 32'h1);
      wr(FKAS_OFS_ARR, 32'hAB);
      @(posedge pclk);
      chk({31'h0, boot_array_sel}, 32'h0);
      $display("test mode %0d done", m);
    end
    // Register rows
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].rexp);
      chk({31'h0, pe_enable}, {31'h0, rows[i].pe});
      chk({31'h0, sw_protect}, {31'h0, ~rows[i].pe});
    end
    $display("test rows done");
    // Programming gate
    wr(FKAS_OFS_KEY, 32'h5A);
    pe_request <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, pe_strobe}, 32'h1);
    pe_request <= 1'b0;
    wr(FKAS_OFS_KEY, 32'hA5);
    pe_request <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, pe_strobe}, 32'h0);
    chk({31'h0, sw_protect}, 32'h1);
    pe_request <= 1'b0;
    $display("test program gate done");
    // Download request
    base = n_start;
    wr(FKAS_OFS_EMUL, 32'h1);
    wr(FKAS_OFS_COPY, 32'h1);
    repeat (3) @(posedge pclk);
    chk(n_start, base);
    wr(FKAS_OFS_EMUL, 32'h0);
    wr(FKAS_OFS_KEY, 32'h3C);
    wr(FKAS_OFS_COPY, 32'h1);
    repeat (3) @(posedge pclk);
    chk(n_start, base);
    wr(FKAS_OFS_KEY, 32'hA5);
    wr(FKAS_OFS_COPY, 32'h1);
    repeat (2) @(posedge pclk);
    chk(n_start, base + 1);
    chk({31'h0, copy_busy}, 32'h1);
    rchk(FKAS_OFS_COPY, 32'h2);
    rchk(FKAS_OFS_STAT, 32'h1C);
    download_done <= 1'b1;
    @(posedge pclk);
    download_done <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, copy_busy}, 32'h0);
    rchk(FKAS_OFS_COPY, 32'h0);
    $display("test download done");
    // Unmapped address and write without the low byte strobe
    apb(1'b1, 8'h20, 32'h77, rdv, erv);
    chk({31'h0, erv}, 32'h1);
    rchk(FKAS_OFS_KEY, 32'hA5);
    pstrb <= 4'hE;
    wr(FKAS_OFS_KEY, 32'h5A);
    pstrb <= 4'hF;
    rchk(FKAS_OFS_KEY, 32'hA5);
    $display("test unmapped done");
    test_done();
  end
endmodule : tb
`default_nettype wire
